/* rpcf_defs.svh */
// Functional notes
// - Station address bits 31:0 from low word
// - Bits 47:32 from high word; Ethernet frames only
// - Bundle-location bit picks UDP source or destination
// - Port-check selector: skip, source, destination; not 11
// - Host ethertype frames: bit 24 forward or drop
// - OAM packets: bit 23 forward or drop
// - Unknown bundle frames: bit 22 forward or drop
// - Service port mismatch: bit 21 forward or drop
// - Non-UDP, non-L2TPv3 IP: bit 20 decides
// - ARP hitting own address: bit 19 decides
// - Ethertype not IP/MPLS/ARP: bit 18 decides
// - IP destination mismatch: bit 17 decides
// - ARP missing own addresses: bit 16 decides
// - Two service ports, both reset 0x085E
// - Host ethertype resets 0x0800, programmed above 0x5DC
// - Bundle-width mask isolates identifier bits
`ifndef RPCF_DEFS_SVH
`define RPCF_DEFS_SVH
// Register byte offsets
`define RPCF_OFS_ADDR_LO 12'h040
`define RPCF_OFS_ADDR_HI 12'h044
`define RPCF_OFS_PORTS 12'h048
`define RPCF_OFS_MASK 12'h050
`define RPCF_OFS_ETYPE 12'h054
`define RPCF_OFS_STATUS 12'h05c
// High word fields
`define RPCF_BIT_BUNDLE_LOC 27
`define RPCF_SEL_HI 26
`define RPCF_SEL_LO 25
`define RPCF_BIT_HOST 24
`define RPCF_BIT_OAM 23
`define RPCF_BIT_BUNDLE 22
`define RPCF_BIT_PORT 21
`define RPCF_BIT_PROTO 20
`define RPCF_BIT_ARP_HIT 19
`define RPCF_BIT_ETYPE 18
`define RPCF_BIT_IP_MISS 17
`define RPCF_BIT_ARP_MISS 16
`define RPCF_HI_KEEP 32'h1fff_ffff
// Reset values
`define RPCF_RST_PORT 16'h085e
`define RPCF_RST_ETYPE 16'h0800
`define RPCF_RST_MASK 16'h0000
// Frame constants
`define RPCF_ET_IP 16'h0800
`define RPCF_ET_ARP 16'h0806
`define RPCF_ET_MPLS 16'h8847
`define RPCF_PROTO_UDP 8'h11
`define RPCF_PROTO_L2TP 8'h73
`define RPCF_BCAST 48'hffff_ffff_ffff
// Byte positions within the frame
`define RPCF_P_DMAC_S 6'h00
`define RPCF_P_DMAC_E 6'h05
`define RPCF_P_ET_S 6'h0c
`define RPCF_P_ET_E 6'h0d
`define RPCF_P_PROTO 6'h17
`define RPCF_P_IPDST_S 6'h1e
`define RPCF_P_IPDST_E 6'h21
`define RPCF_P_USRC_S 6'h22
`define RPCF_P_USRC_E 6'h23
`define RPCF_P_UDST_S 6'h24
`define RPCF_P_UDST_E 6'h25
`define RPCF_P_TPA_S 6'h26
`define RPCF_P_TPA_E 6'h29
`endif

/* rpcf_pkg.sv */
package rpcf_pkg;
  typedef enum logic [1:0] {
    ST_RECV = 2'h0,
    ST_LOOK = 2'h1,
    ST_PUSH = 2'h3
  } rpcf_state_t;
  typedef enum logic [1:0] {
    DST_PAYLOAD = 2'h0,
    DST_CPU = 2'h1,
    DST_DROP = 2'h2
  } rpcf_dest_t;
  typedef enum logic [3:0] {
    RSN_PAYLOAD = 4'h0, RSN_MAC = 4'h1, RSN_HOST = 4'h2, RSN_ETYPE = 4'h3,
    RSN_ARP_HIT = 4'h4, RSN_ARP_MISS = 4'h5, RSN_IP_MISS = 4'h6, RSN_PROTO = 4'h7,
    RSN_PORT = 4'h8, RSN_OAM = 4'h9, RSN_BUNDLE = 4'ha
  } rpcf_reason_t;
endpackage

/* rpcf_fifo.sv */
`timescale 1ns/100ps
module rpcf_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic do_push, do_pop;

  // Wrap pointer at depth, which need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) return '0;
    return p + 1'b1;
  endfunction

  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Pointer and fill level next values
  always_comb begin
    next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = do_pop ? bump(rd_ptr) : rd_ptr;
    next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  // Flags registered from next level, so ready never lies
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  a_fifo_full_stall: assert property (@(posedge clock) disable iff (rst)
    count == (AW+1)'(DEPTH) |-> !in_ready && out_valid)
    else $error("full fifo still ready");
  a_fifo_empty_idle: assert property (@(posedge clock) disable iff (rst)
    count == '0 |-> !out_valid ##0 in_ready)
    else $error("empty fifo shows data");
endmodule

/* rpcf_decide.sv */
`timescale 1ns/100ps
`include "rpcf_defs.svh"
module rpcf_decide
  import rpcf_pkg::*;
(
  // Captured frame fields
  input wire logic from_eth,
  input wire logic [47:0] dst_mac,
  input wire logic [15:0] etype,
  input wire logic [7:0] proto,
  input wire logic [31:0] ip_dst,
  input wire logic [31:0] arp_tpa,
  input wire logic [15:0] udp_src,
  input wire logic [15:0] udp_dst,
  // Configuration
  input wire logic [47:0] station_addr,
  input wire logic [31:0] ctrl,
  input wire logic [15:0] host_etype,
  input wire logic [15:0] port_a,
  input wire logic [15:0] port_b,
  input wire logic [31:0] ip_a,
  input wire logic [31:0] ip_b,
  input wire logic [31:0] ip_c,
  // Bundle lookup answer
  input wire logic bundle_known,
  input wire logic bundle_oam,
  // Verdict
  output rpcf_dest_t dest,
  output rpcf_reason_t reason
);
  logic [1:0] sel;
  logic [15:0] chk_port;
  logic port_hit;

  function automatic logic addr_hit(input logic [31:0] a);
    return a == ip_a || a == ip_b || a == ip_c;
  endfunction

  function automatic rpcf_dest_t steer(input logic discard);
    return discard ? DST_DROP : DST_CPU;
  endfunction

  // Ordered checks: first category that applies decides
  always_comb begin
    sel = ctrl[`RPCF_SEL_HI:`RPCF_SEL_LO];
    chk_port = (sel == 2'h1) ? udp_src : udp_dst;
    port_hit = (sel != 2'h1 && sel != 2'h2) || chk_port == port_a || chk_port == port_b;
    dest = DST_PAYLOAD;
    reason = RSN_PAYLOAD;
    if (from_eth && dst_mac != station_addr && dst_mac != `RPCF_BCAST) begin
      dest = DST_DROP;
      reason = RSN_MAC;
    end else if (etype == host_etype) begin
      dest = steer(ctrl[`RPCF_BIT_HOST]);
      reason = RSN_HOST;
    end else if (etype != `RPCF_ET_IP && etype != `RPCF_ET_ARP && etype != `RPCF_ET_MPLS) begin
      dest = steer(ctrl[`RPCF_BIT_ETYPE]);
      reason = RSN_ETYPE;
    end else if (etype == `RPCF_ET_ARP) begin
      dest = steer(addr_hit(arp_tpa) ? ctrl[`RPCF_BIT_ARP_HIT] : ctrl[`RPCF_BIT_ARP_MISS]);
      reason = addr_hit(arp_tpa) ? RSN_ARP_HIT : RSN_ARP_MISS;
    end else if (etype == `RPCF_ET_IP) begin
      if (!addr_hit(ip_dst)) begin
        dest = steer(ctrl[`RPCF_BIT_IP_MISS]);
        reason = RSN_IP_MISS;
      end else if (proto != `RPCF_PROTO_UDP && proto != `RPCF_PROTO_L2TP) begin
        dest = steer(ctrl[`RPCF_BIT_PROTO]);
        reason = RSN_PROTO;
      end else if (proto == `RPCF_PROTO_UDP) begin
        if (!port_hit) begin
          dest = steer(ctrl[`RPCF_BIT_PORT]);
          reason = RSN_PORT;
        end else if (bundle_oam) begin
          dest = steer(ctrl[`RPCF_BIT_OAM]);
          reason = RSN_OAM;
        end else if (!bundle_known) begin
          dest = steer(ctrl[`RPCF_BIT_BUNDLE]);
          reason = RSN_BUNDLE;
        end
      end
    end
  end
endmodule

/* rpcf_top.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "rpcf_defs.svh"
module rpcf_top
  import rpcf_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Receive byte stream from MAC
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic rx_from_eth,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Device IPv4 addresses
  input wire logic [31:0] dev_ip_a,
  input wire logic [31:0] dev_ip_b,
  input wire logic [31:0] dev_ip_c,
  // Bundle table lookup
  output logic lookup_req,
  output logic [15:0] lookup_bundle_id,
  input wire logic bundle_known,
  input wire logic bundle_oam,
  // Verdict queue
  output logic cls_valid,
  output logic [21:0] cls_data,
  input wire logic cls_ready
);
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [31:0] addr_lo, next_addr_lo;
  logic [31:0] addr_hi, next_addr_hi;
  logic [15:0] port_a, next_port_a;
  logic [15:0] port_b, next_port_b;
  logic [15:0] bundle_mask, next_bundle_mask;
  logic [15:0] host_etype, next_host_etype;
  logic [15:0] fwd_count, next_fwd_count;
  logic [15:0] drop_count, next_drop_count;
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic apb_done, apb_wr;
  logic [32:0] rd_word;

  // Read map: bit 32 flags a mapped address
  function automatic logic [32:0] read_map(input logic [11:0] a);
    case (a)
      `RPCF_OFS_ADDR_LO: return {1'b1, addr_lo};
      `RPCF_OFS_ADDR_HI: return {1'b1, addr_hi};
      `RPCF_OFS_PORTS: return {1'b1, port_b, port_a};
      `RPCF_OFS_MASK: return {1'b1, bundle_mask, 16'h0000};
      `RPCF_OFS_ETYPE: return {1'b1, host_etype, 16'h0000};
      `RPCF_OFS_STATUS: return {1'b1, drop_count, fwd_count};
      default: return 33'h0_0000_0000;
    endcase
  endfunction

  assign apb_done = psel && penable && pready;
  assign apb_wr = apb_done && pwrite;

  // One wait state; data and error are set up with pready
  always_comb begin
    rd_word = read_map(paddr);
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (next_pready) begin
      next_prdata = pwrite ? 32'h0000_0000 : rd_word[31:0];
      next_pslverr = !rd_word[32] || (pwrite && paddr == `RPCF_OFS_STATUS);
    end
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_port_a = port_a;
    next_port_b = port_b;
    next_bundle_mask = bundle_mask;
    next_host_etype = host_etype;
    if (apb_wr && paddr == `RPCF_OFS_ADDR_LO) begin
      next_addr_lo = pwdata;
    end
    if (apb_wr && paddr == `RPCF_OFS_ADDR_HI) begin
      // Reserved top bits never stored, so they read as zero
      next_addr_hi = pwdata & `RPCF_HI_KEEP;
    end
    if (apb_wr && paddr == `RPCF_OFS_PORTS) begin
      next_port_a = pwdata[15:0];
      next_port_b = pwdata[31:16];
    end
    if (apb_wr && paddr == `RPCF_OFS_MASK) begin
      next_bundle_mask = pwdata[31:16];
    end
    if (apb_wr && paddr == `RPCF_OFS_ETYPE) begin
      next_host_etype = pwdata[31:16];
    end
  end

  // Configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      addr_lo <= 32'h0000_0000;
      addr_hi <= 32'h0000_0000;
      port_a <= `RPCF_RST_PORT;
      port_b <= `RPCF_RST_PORT;
      bundle_mask <= `RPCF_RST_MASK;
      host_etype <= `RPCF_RST_ETYPE;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      port_a <= next_port_a;
      port_b <= next_port_b;
      bundle_mask <= next_bundle_mask;
      host_etype <= next_host_etype;
    end
  end

  // ------------------------------------------------------------
  // Header capture
  // ------------------------------------------------------------
  logic [5:0] byte_cnt, next_byte_cnt, pos;
  logic take, from_eth, next_from_eth;
  logic [47:0] dst_mac, next_dst_mac;
  logic [15:0] etype, next_etype;
  logic [7:0] proto, next_proto;
  logic [31:0] ip_dst, next_ip_dst;
  logic [31:0] arp_tpa, next_arp_tpa;
  logic [15:0] udp_src, next_udp_src;
  logic [15:0] udp_dst, next_udp_dst;

  function automatic logic in_span(input logic [5:0] p, input logic [5:0] s,
                                   input logic [5:0] e);
    return p >= s && p <= e;
  endfunction

  assign take = rx_valid && rx_ready;
  assign pos = rx_sof ? 6'h00 : byte_cnt;

  // Shift each field in as its bytes pass; counter saturates past header
  always_comb begin
    next_byte_cnt = byte_cnt;
    next_from_eth = from_eth;
    next_dst_mac = dst_mac;
    next_etype = etype;
    next_proto = proto;
    next_ip_dst = ip_dst;
    next_arp_tpa = arp_tpa;
    next_udp_src = udp_src;
    next_udp_dst = udp_dst;
    if (take) begin
      next_byte_cnt = (pos == 6'h3f) ? pos : pos + 6'h01;
      if (rx_sof) begin
        next_from_eth = rx_from_eth;
      end
      if (in_span(pos, `RPCF_P_DMAC_S, `RPCF_P_DMAC_E)) begin
        next_dst_mac = {dst_mac[39:0], rx_data};
      end
      if (in_span(pos, `RPCF_P_ET_S, `RPCF_P_ET_E)) begin
        next_etype = {etype[7:0], rx_data};
      end
      if (pos == `RPCF_P_PROTO) begin
        next_proto = rx_data;
      end
      if (in_span(pos, `RPCF_P_IPDST_S, `RPCF_P_IPDST_E)) begin
        next_ip_dst = {ip_dst[23:0], rx_data};
      end
      if (in_span(pos, `RPCF_P_USRC_S, `RPCF_P_USRC_E)) begin
        next_udp_src = {udp_src[7:0], rx_data};
      end
      if (in_span(pos, `RPCF_P_UDST_S, `RPCF_P_UDST_E)) begin
        next_udp_dst = {udp_dst[7:0], rx_data};
      end
      if (in_span(pos, `RPCF_P_TPA_S, `RPCF_P_TPA_E)) begin
        next_arp_tpa = {arp_tpa[23:0], rx_data};
      end
    end
  end

  // Header field registers
  always_ff @(posedge clock) begin
    if (rst) begin
      byte_cnt <= 6'h00;
      from_eth <= 1'b0;
      dst_mac <= 48'h0000_0000_0000;
      etype <= 16'h0000;
      proto <= 8'h00;
      ip_dst <= 32'h0000_0000;
      arp_tpa <= 32'h0000_0000;
      udp_src <= 16'h0000;
      udp_dst <= 16'h0000;
    end else begin
      byte_cnt <= next_byte_cnt;
      from_eth <= next_from_eth;
      dst_mac <= next_dst_mac;
      etype <= next_etype;
      proto <= next_proto;
      ip_dst <= next_ip_dst;
      arp_tpa <= next_arp_tpa;
      udp_src <= next_udp_src;
      udp_dst <= next_udp_dst;
    end
  end

  // ------------------------------------------------------------
  // Verdict sequencer
  // ------------------------------------------------------------
  rpcf_state_t state, next_state;
  rpcf_dest_t dec_dest, verdict_dest, next_verdict_dest;
  rpcf_reason_t dec_reason, verdict_reason, next_verdict_reason;
  logic [15:0] next_bundle_id;
  logic next_rx_ready, next_lookup_req;
  logic fifo_in_ready, fifo_push;

  rpcf_decide u_decide (
    .from_eth(from_eth),
    .dst_mac(dst_mac),
    .etype(etype),
    .proto(proto),
    .ip_dst(ip_dst),
    .arp_tpa(arp_tpa),
    .udp_src(udp_src),
    .udp_dst(udp_dst),
    .station_addr({addr_hi[15:0], addr_lo}),
    .ctrl(addr_hi),
    .host_etype(host_etype),
    .port_a(port_a),
    .port_b(port_b),
    .ip_a(dev_ip_a),
    .ip_b(dev_ip_b),
    .ip_c(dev_ip_c),
    .bundle_known(bundle_known),
    .bundle_oam(bundle_oam),
    .dest(dec_dest),
    .reason(dec_reason)
  );

  assign fifo_push = state == ST_PUSH;

  // Stream stalls while the verdict waits, so a full queue holds the MAC
  always_comb begin
    next_state = state;
    next_bundle_id = lookup_bundle_id;
    next_verdict_dest = verdict_dest;
    next_verdict_reason = verdict_reason;
    next_fwd_count = fwd_count;
    next_drop_count = drop_count;
    unique case (state)
      ST_RECV: begin
        if (take && rx_eof) begin
          next_state = ST_LOOK;
          // Uses next values so a last header byte on eof still counts
          next_bundle_id = (addr_hi[`RPCF_BIT_BUNDLE_LOC] ? next_udp_dst : next_udp_src)
                           & bundle_mask;
        end
      end
      ST_LOOK: begin
        next_state = ST_PUSH;
        next_verdict_dest = dec_dest;
        next_verdict_reason = dec_reason;
      end
      ST_PUSH: begin
        if (fifo_in_ready) begin
          next_state = ST_RECV;
          if (verdict_dest == DST_DROP) begin
            next_drop_count = drop_count + 16'h0001;
          end else begin
            next_fwd_count = fwd_count + 16'h0001;
          end
        end
      end
      default: next_state = ST_RECV;
    endcase
    next_rx_ready = next_state == ST_RECV;
    next_lookup_req = next_state == ST_LOOK;
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_RECV;
      lookup_bundle_id <= 16'h0000;
      verdict_dest <= DST_PAYLOAD;
      verdict_reason <= RSN_PAYLOAD;
      fwd_count <= 16'h0000;
      drop_count <= 16'h0000;
      rx_ready <= 1'b1;
      lookup_req <= 1'b0;
    end else begin
      state <= next_state;
      lookup_bundle_id <= next_bundle_id;
      verdict_dest <= next_verdict_dest;
      verdict_reason <= next_verdict_reason;
      fwd_count <= next_fwd_count;
      drop_count <= next_drop_count;
      rx_ready <= next_rx_ready;
      lookup_req <= next_lookup_req;
    end
  end

  // Four-deep queue absorbs short host stalls between verdicts
  rpcf_fifo #(
    .WIDTH(22),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({verdict_dest, verdict_reason, lookup_bundle_id}),
    .out_valid(cls_valid),
    .out_ready(cls_ready),
    .out_data(cls_data)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_wr_done(logic [11:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  sequence s_frame_end;
    take && rx_eof && state == ST_RECV;
  endsequence

  a_mac_low_store: assert property (
    @(posedge clock) disable iff (rst)
    s_wr_done(`RPCF_OFS_ADDR_LO) |=> addr_lo == $past(pwdata))
    else $error("low station word not stored");
  a_mac_high_store: assert property (
    @(posedge clock) disable iff (rst)
    s_wr_done(`RPCF_OFS_ADDR_HI) |=> addr_hi[15:0] == $past(pwdata[15:0])
      && addr_hi[31:29] == 3'h0)
    else $error("high station word wrong");
  a_bundle_pick: assert property (
    @(posedge clock) disable iff (rst)
    state == ST_LOOK |-> lookup_req && lookup_bundle_id ==
      ((addr_hi[`RPCF_BIT_BUNDLE_LOC] ? udp_dst : udp_src) & bundle_mask))
    else $error("bundle id from wrong port");
  a_port_reset: assert property (
    @(posedge clock) disable iff (rst)
    $fell(rst) |-> port_a == `RPCF_RST_PORT && port_b == `RPCF_RST_PORT)
    else $error("service ports reset wrong");
  a_etype_reset: assert property (
    @(posedge clock) disable iff (rst)
    $fell(rst) |-> host_etype == `RPCF_RST_ETYPE)
    else $error("host ethertype reset wrong");
  a_host_first: assert property (
    @(posedge clock) disable iff (rst)
    state == ST_LOOK && (!from_eth || dst_mac == {addr_hi[15:0], addr_lo})
      && etype == host_etype |=> verdict_reason == RSN_HOST &&
      verdict_dest == ($past(addr_hi[`RPCF_BIT_HOST]) ? DST_DROP : DST_CPU))
    else $error("host ethertype not steered first");
  a_other_etype: assert property (
    @(posedge clock) disable iff (rst)
    state == ST_LOOK && (!from_eth || dst_mac == {addr_hi[15:0], addr_lo}) && etype != host_etype
      && etype != `RPCF_ET_IP && etype != `RPCF_ET_ARP && etype != `RPCF_ET_MPLS |=>
      verdict_dest == ($past(addr_hi[`RPCF_BIT_ETYPE]) ? DST_DROP : DST_CPU))
    else $error("foreign ethertype misrouted");
  a_rx_stall: assert property (
    @(posedge clock) disable iff (rst)
    s_frame_end |=> !rx_ready ##1 !rx_ready)
    else $error("stream not stalled after frame end");
  a_verdict_hold: assert property (
    @(posedge clock) disable iff (rst)
    state == ST_PUSH && !fifo_in_ready |=> state == ST_PUSH && $stable(verdict_dest))
    else $error("verdict lost while queue full");
  a_apb_wait: assert property (
    @(posedge clock) disable iff (rst)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule

/* rpcf_mac_model.sv */
`timescale 1ns/100ps
// ----
// MAC receive side and bundle table
// ----
module rpcf_mac_model (
  // System
  input wire logic clock,
  // Byte stream
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_from_eth,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Bundle lookup
  input wire logic [15:0] lookup_bundle_id,
  output logic bundle_known,
  output logic bundle_oam
);
  logic [7:0] f [0:41];
  // Fixed table: id 5 assigned, id 7 OAM
  assign bundle_known = lookup_bundle_id == 16'h0005;
  assign bundle_oam = lookup_bundle_id == 16'h0007;
  initial begin
    {rx_valid, rx_sof, rx_eof} = 3'h0;
    rx_from_eth = 1'b1;
    rx_data = 8'h5a;
  end
  // Header-only frame; each byte held until taken
  task automatic send(input logic [47:0] da, input logic [15:0] et, input logic [7:0] pr,
                      input logic [31:0] ip, input logic [15:0] us, input logic [15:0] ud,
                      input logic fe = 1'b1);
    f = '{default: 8'h00};
    {f[0], f[1], f[2], f[3], f[4], f[5]} = da;
    {f[12], f[13]} = et;
    f[23] = pr;
    {f[30], f[31], f[32], f[33]} = ip;
    {f[34], f[35], f[36], f[37]} = {us, ud};
    {f[38], f[39], f[40], f[41]} = ip;
    @(posedge clock);
    for (int i = 0; i < 42; i++) begin
      rx_valid <= 1'b1;
      rx_from_eth <= fe;
      rx_sof <= i == 0;
      rx_eof <= i == 41;
      rx_data <= f[i];
      @(posedge clock);
      while (rx_ready !== 1'b1) @(posedge clock);
    end
    rx_valid <= 1'b0;
    // Released line shows no stale byte
    rx_data <= ~f[41];
  endtask
endmodule

/* rpcf_top_tb.sv */
`timescale 1ns/100ps
module rpcf_top_tb;
  localparam logic [31:0] IA = 32'h0a00_0001;
  localparam logic [31:0] IM = 32'h0b00_0000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cls_ready = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, rx_valid, rx_sof, rx_eof, rx_from_eth, rx_ready;
  logic lookup_req, bundle_known, bundle_oam, cls_valid;
  logic [7:0] rx_data;
  logic [15:0] bid;
  logic [21:0] cls_data;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2 clock = ~clock;
  rpcf_top #(.FIFO_DEPTH(4)) dut_u (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .rx_valid, .rx_sof, .rx_eof, .rx_from_eth,
    .rx_data, .rx_ready, .dev_ip_a(IA), .dev_ip_b(32'h0a00_0002), .dev_ip_c(32'h0a00_0003),
    .lookup_req, .lookup_bundle_id(bid), .bundle_known, .bundle_oam, .cls_valid, .cls_data,
    .cls_ready);
  rpcf_mac_model mac (.clock, .rx_valid, .rx_sof, .rx_eof, .rx_from_eth, .rx_data,
    .rx_ready, .lookup_bundle_id(bid), .bundle_known, .bundle_oam);
  // ----
  // Shared tasks
  // ----
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "read");
  endtask
  // Head verdict taken at the popping edge
  task automatic pop(input logic [5:0] e, input logic [15:0] id);
    @(posedge clock);
    while (cls_valid !== 1'b1) @(posedge clock);
    chk({10'h0, cls_data}, {10'h0, e, id}, "verdict");
  endtask
  // Control half in c; bundle id is the chosen port under mask 0x00ff
  task automatic frm(input logic [15:0] c, input logic [15:0] et, input logic [5:0] e,
                     input logic [7:0] pr = 8'h11, input logic [31:0] ip = IA,
                     input logic [15:0] us = 16'h1205, input logic [15:0] ud = 16'h085e,
                     input logic m = 1'b0, input logic fe = 1'b1);
    apb(1'b1, 12'h044, {c, 16'h1122});
    mac.send(m ? 48'h1122_3344_5567 : 48'h1122_3344_5566, et, pr, ip, us, ud, fe);
    pop(e, (c[11] ? ud : us) & 16'h00ff);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic regs;
    rdchk(12'h040, 32'h0);
    rdchk(12'h044, 32'h0);
    rdchk(12'h048, 32'h085e_085e);
    rdchk(12'h054, 32'h0800_0000);
    apb(1'b1, 12'h040, 32'h3344_5566);
    apb(1'b1, 12'h044, 32'h0400_1122);
    apb(1'b1, 12'h050, 32'h00ff_0000);
    apb(1'b1, 12'h054, 32'h0900_0000);
    rdchk(12'h040, 32'h3344_5566);
    rdchk(12'h044, 32'h0400_1122);
    rdchk(12'h050, 32'h00ff_0000);
    apb(1'b0, 12'h04c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
  endtask
  task automatic classify;
    frm(16'h0400, 16'h0800, 6'h21, 8'h11, IA, 16'h1205, 16'h085e, 1'b1);
    frm(16'h0400, 16'h0800, 6'h00, 8'h11, IA, 16'h1205, 16'h085e, 1'b1, 1'b0);
    frm(16'h0400, 16'h0900, 6'h12);
    frm(16'h0500, 16'h0900, 6'h22);
    frm(16'h0400, 16'h1234, 6'h13);
    frm(16'h0404, 16'h1234, 6'h23);
    frm(16'h0404, 16'h8847, 6'h00);
    frm(16'h0400, 16'h0806, 6'h14, 8'h11, 32'h0a00_0002);
    frm(16'h0408, 16'h0806, 6'h24);
    frm(16'h0400, 16'h0806, 6'h15, 8'h11, IM);
    frm(16'h0401, 16'h0806, 6'h25, 8'h11, IM);
    frm(16'h0400, 16'h0800, 6'h16, 8'h11, IM);
    frm(16'h0402, 16'h0800, 6'h26, 8'h11, IM);
    frm(16'h0400, 16'h0800, 6'h17, 8'h06, 32'h0a00_0003);
    frm(16'h0410, 16'h0800, 6'h27, 8'h06);
    frm(16'h0400, 16'h0800, 6'h18, 8'h11, IA, 16'h1205, 16'h1111);
    frm(16'h0420, 16'h0800, 6'h28, 8'h11, IA, 16'h1205, 16'h1111);
    frm(16'h0000, 16'h0800, 6'h00, 8'h11, IA, 16'h1205, 16'h1111);
    frm(16'h0200, 16'h0800, 6'h18, 8'h11, IA, 16'h1205, 16'h1111);
    frm(16'h0200, 16'h0800, 6'h1a, 8'h11, IA, 16'h085e, 16'h1111);
    frm(16'h0a00, 16'h0800, 6'h19, 8'h11, IA, 16'h085e, 16'h3407);
    frm(16'h0a80, 16'h0800, 6'h29, 8'h11, IA, 16'h085e, 16'h3407);
    frm(16'h0400, 16'h0800, 6'h1a, 8'h11, IA, 16'h1299);
    frm(16'h0440, 16'h0800, 6'h2a, 8'h11, IA, 16'h1299);
    frm(16'h0400, 16'h0800, 6'h00);
  endtask
  // Queue full stalls the stream; drain keeps order
  task automatic fill;
    apb(1'b1, 12'h044, 32'h0400_1122);
    cls_ready <= 1'b0;
    for (int k = 1; k < 6; k++) begin
      mac.send(48'h1122_3344_5566, 16'h0800, 8'h11, IA, {12'h120, 4'(k)}, 16'h085e);
    end
    repeat (8) @(posedge clock);
    chk({31'h0, rx_ready}, 32'h0, "stall");
    cls_ready <= 1'b1;
    for (int k = 1; k < 6; k++) begin
      pop(k == 5 ? 6'h00 : 6'h1a, {12'h000, 4'(k)});
    end
    repeat (2) @(posedge clock);
    chk({31'h0, cls_valid}, 32'h0, "empty");
    rdchk(12'h05c, 32'h000a_0014);
  endtask
  // Reset for two edges, then the scenarios
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    regs;
    classify;
    fill;
    end_sim;
  end
  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim;
  end
endmodule
